/* rtl/pid_mode_sequencer.sv */
// loop mode sequencer: pre-loop start, sleep, wake, gain switch, bypass, display scaling
// Function
// - unit codes 11,12 show Celsius, Fahrenheit; 13 to 16 custom units
// - displayed value scaled by unit gain and unit scale
// - asserted terminal with code 24 selects alternate proportional gain
// - on run, drive the pre-loop frequency until feedback exceeds exit level
// - feedback above exit level starts closed loop control
// - nonzero fail delay elapsed below exit level trips fault, blocks output
// - frequency below sleep frequency for sleep delay stops output, enters sleep
// - sleep keeps output stopped until wake condition, then loop resumes
// - entering sleep raises warning and shows sleep code on keypad
// - wake mode 0 wakes when feedback below wake level
// - wake mode 1 wakes when feedback above wake level
// - wake mode 2 wakes when reference minus feedback exceeds wake level
// - terminal with code 23 asserted runs general operation instead of loop
`include "pms_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module pid_mode_sequencer #(
  parameter int TICK_CYCLES = `PMS_TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [6:0] termPins,
  input wire logic [15:0] feedback,
  input wire logic [15:0] reference,
  input wire logic [15:0] operatingFreq,
  input wire logic [15:0] loopFreq,
  input wire logic [15:0] generalFreq,
  output logic [15:0] freqCmd,
  output logic outputEnable,
  output logic loopActive,
  output logic preLoopFault,
  output logic sleepWarning,
  output logic [7:0] keypadCode,
  output logic [15:0] activePGain,
  output logic [15:0] activeITerm,
  output logic [2:0] unitClass,
  output logic [15:0] displayValue,
  output logic irq
);

  // settings
  logic runEn_r;
  logic [15:0] preLoopFrequency_r;
  logic [15:0] preLoopExitLevel_r;
  logic [15:0] preLoopFailDelay_r;
  logic [15:0] sleepDelayTime_r;
  logic [15:0] sleepFrequency_r;
  logic [15:0] wakeupLevel_r;
  logic [1:0] wakeupModeSelect_r;
  logic [4:0] displayUnitSelect_r;
  logic [15:0] displayUnitGain_r;
  logic [3:0] displayUnitScale_r;
  logic [15:0] alternateProportionalGain_r;
  logic [15:0] primaryProportionalGain_r;
  logic [15:0] primaryIntegralTerm_r;
  logic [7:0] termFunc_r [0:`PMS_TERM_N-1];
  logic [`PMS_IRQ_W-1:0] irqStat_r;
  logic [`PMS_IRQ_W-1:0] irqMask_r;

  // sequencing state
  pms_pkg::pms_state_t state_r;
  pms_pkg::pms_state_t state_nxt;
  logic [6:0] termMeta_r;
  logic [6:0] termSync_r;
  logic [31:0] tickCnt_r;
  logic tick_r;
  logic [15:0] preTimer_r;
  logic [15:0] sleepTimer_r;
  logic gainSwitch;
  logic loopBypass;
  logic wakeHit;
  logic preExit;
  logic preFail;
  logic sleepHit;
  logic [`PMS_IRQ_W-1:0] irqEvent;
  logic [31:0] product;
  logic [31:0] readData;
  logic mapped;
  logic wrStrobe;
  logic rdStrobe;
  logic faultClr;

  // bus transfer completes on the cycle pready is high
  assign wrStrobe = psel & penable & pready & pwrite;
  assign rdStrobe = psel & penable & pready & ~pwrite;
  assign faultClr = wrStrobe & (paddr == `PMS_OFS_CTRL) & pwdata[`PMS_CTRL_FAULT_CLR];

  // terminal pins come from outside, two flops before use
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      termMeta_r <= 7'h00;
      termSync_r <= 7'h00;
    end else begin
      termMeta_r <= termPins;
      termSync_r <= termMeta_r;
    end
  end

  // terminal function decode
  always_comb begin
    gainSwitch = 1'b0;
    loopBypass = 1'b0;
    for (int i = 0; i < `PMS_TERM_N; i++) begin
      if (termSync_r[i] && termFunc_r[i] == `PMS_FUNC_GAIN_SWITCH) begin
        gainSwitch = 1'b1;
      end
      if (termSync_r[i] && termFunc_r[i] == `PMS_FUNC_LOOP_BYPASS) begin
        loopBypass = 1'b1;
      end
    end
  end

  // millisecond tick divider
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tickCnt_r <= 32'h0;
      tick_r <= 1'b0;
    end else if (tickCnt_r >= 32'(TICK_CYCLES - 1)) begin
      tickCnt_r <= 32'h0;
      tick_r <= 1'b1;
    end else begin
      tickCnt_r <= tickCnt_r + 32'h1;
      tick_r <= 1'b0;
    end
  end

  // wake-up criterion by mode
  always_comb begin
    case (wakeupModeSelect_r)
      `PMS_WAKE_BELOW: wakeHit = feedback < wakeupLevel_r;
      `PMS_WAKE_ABOVE: wakeHit = feedback > wakeupLevel_r;
      `PMS_WAKE_BEYOND: wakeHit = (reference > feedback) &&
                                  ((reference - feedback) > wakeupLevel_r);
      default: wakeHit = 1'b0;
    endcase
  end

  // transition conditions
  assign preExit = feedback > preLoopExitLevel_r;
  assign preFail = (preLoopFailDelay_r != 16'h0) && (preTimer_r >= preLoopFailDelay_r);
  assign sleepHit = ~loopBypass && (operatingFreq < sleepFrequency_r) &&
                    (sleepTimer_r >= sleepDelayTime_r);

  // next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      pms_pkg::PMS_IDLE: begin
        if (runEn_r) begin
          state_nxt = pms_pkg::PMS_PRE;
        end
      end
      pms_pkg::PMS_PRE: begin
        if (!runEn_r) begin
          state_nxt = pms_pkg::PMS_IDLE;
        end else if (preExit) begin
          state_nxt = pms_pkg::PMS_LOOP;
        end else if (preFail) begin
          state_nxt = pms_pkg::PMS_FAULT;
        end
      end
      pms_pkg::PMS_LOOP: begin
        if (!runEn_r) begin
          state_nxt = pms_pkg::PMS_IDLE;
        end else if (sleepHit) begin
          state_nxt = pms_pkg::PMS_SLEEP;
        end
      end
      pms_pkg::PMS_SLEEP: begin
        if (!runEn_r) begin
          state_nxt = pms_pkg::PMS_IDLE;
        end else if (wakeHit) begin
          state_nxt = pms_pkg::PMS_LOOP;
        end
      end
      pms_pkg::PMS_FAULT: begin
        if (faultClr) begin
          state_nxt = pms_pkg::PMS_IDLE;
        end
      end
      default: state_nxt = pms_pkg::PMS_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_r <= pms_pkg::PMS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // pre-loop fail timer, counts ms spent below exit level
  always_ff @(posedge ref_clk) begin
    if (srst || state_r != pms_pkg::PMS_PRE) begin
      preTimer_r <= 16'h0;
    end else if (tick_r && preTimer_r != 16'hffff) begin
      preTimer_r <= preTimer_r + 16'h1;
    end
  end

  // sleep delay timer, restarts when frequency recovers
  always_ff @(posedge ref_clk) begin
    if (srst || state_r != pms_pkg::PMS_LOOP) begin
      sleepTimer_r <= 16'h0;
    end else if (loopBypass || operatingFreq >= sleepFrequency_r) begin
      sleepTimer_r <= 16'h0;
    end else if (tick_r && sleepTimer_r != 16'hffff) begin
      sleepTimer_r <= sleepTimer_r + 16'h1;
    end
  end

  // drive outputs toward the power stage
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      freqCmd <= 16'h0;
      outputEnable <= 1'b0;
      loopActive <= 1'b0;
      preLoopFault <= 1'b0;
      sleepWarning <= 1'b0;
      keypadCode <= 8'h00;
    end else begin
      preLoopFault <= state_nxt == pms_pkg::PMS_FAULT;
      sleepWarning <= state_nxt == pms_pkg::PMS_SLEEP;
      keypadCode <= (state_nxt == pms_pkg::PMS_SLEEP) ? `PMS_SLEEP_DISPLAY_CODE : 8'h00;
      case (state_nxt)
        pms_pkg::PMS_PRE: begin
          freqCmd <= preLoopFrequency_r;
          outputEnable <= 1'b1;
          loopActive <= 1'b0;
        end
        pms_pkg::PMS_LOOP: begin
          freqCmd <= loopBypass ? generalFreq : loopFreq;
          outputEnable <= 1'b1;
          loopActive <= ~loopBypass;
        end
        default: begin
          freqCmd <= 16'h0;
          outputEnable <= 1'b0;
          loopActive <= 1'b0;
        end
      endcase
    end
  end

  // gain selection
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      activePGain <= 16'h0;
      activeITerm <= 16'h0;
    end else begin
      activePGain <= gainSwitch ? alternateProportionalGain_r : primaryProportionalGain_r;
      activeITerm <= primaryIntegralTerm_r;
    end
  end

  // unit class and scaled display
  assign product = feedback * displayUnitGain_r;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      unitClass <= 3'(pms_pkg::PMS_CLS_PERCENT);
      displayValue <= 16'h0;
    end else begin
      displayValue <= 16'(product >> displayUnitScale_r);
      if (displayUnitSelect_r == `PMS_UNIT_CELSIUS) begin
        unitClass <= 3'(pms_pkg::PMS_CLS_CELSIUS);
      end else if (displayUnitSelect_r == `PMS_UNIT_FAHRENHEIT) begin
        unitClass <= 3'(pms_pkg::PMS_CLS_FAHRENHEIT);
      end else if (displayUnitSelect_r >= `PMS_UNIT_CUSTOM_LO &&
                   displayUnitSelect_r <= `PMS_UNIT_CUSTOM_HI) begin
        unitClass <= 3'(pms_pkg::PMS_CLS_CUSTOM);
      end else if (displayUnitSelect_r >= 5'h07) begin
        unitClass <= 3'(pms_pkg::PMS_CLS_ELECTRIC);
      end else if (displayUnitSelect_r >= 5'h05) begin
        unitClass <= 3'(pms_pkg::PMS_CLS_SPEED);
      end else if (displayUnitSelect_r >= 5'h01) begin
        unitClass <= 3'(pms_pkg::PMS_CLS_PRESSURE);
      end else begin
        unitClass <= 3'(pms_pkg::PMS_CLS_PERCENT);
      end
    end
  end

  // events and interrupt; set wins over read clear
  always_comb begin
    irqEvent = '0;
    irqEvent[`PMS_IRQ_PRE_FAIL] = state_r == pms_pkg::PMS_PRE && state_nxt == pms_pkg::PMS_FAULT;
    irqEvent[`PMS_IRQ_SLEEP] = state_r == pms_pkg::PMS_LOOP && state_nxt == pms_pkg::PMS_SLEEP;
    irqEvent[`PMS_IRQ_WAKE] = state_r == pms_pkg::PMS_SLEEP && state_nxt == pms_pkg::PMS_LOOP;
    irqEvent[`PMS_IRQ_LOOP_START] = state_r == pms_pkg::PMS_PRE && state_nxt == pms_pkg::PMS_LOOP;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irqStat_r <= '0;
      irq <= 1'b0;
    end else begin
      if (rdStrobe && paddr == `PMS_OFS_IRQ_STAT) begin
        irqStat_r <= irqEvent;
      end else begin
        irqStat_r <= irqStat_r | irqEvent;
      end
      irq <= |((irqStat_r | irqEvent) & irqMask_r);
    end
  end

  // register writes
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      runEn_r <= 1'b0;
      preLoopFrequency_r <= 16'h0;
      preLoopExitLevel_r <= 16'h0;
      preLoopFailDelay_r <= 16'h0;
      sleepDelayTime_r <= 16'h0;
      sleepFrequency_r <= 16'h0;
      wakeupLevel_r <= 16'h0;
      wakeupModeSelect_r <= 2'h0;
      displayUnitSelect_r <= 5'h00;
      displayUnitGain_r <= 16'h0001;
      displayUnitScale_r <= 4'h0;
      alternateProportionalGain_r <= 16'h0;
      primaryProportionalGain_r <= 16'h0;
      primaryIntegralTerm_r <= 16'h0;
      irqMask_r <= '0;
      for (int i = 0; i < `PMS_TERM_N; i++) begin
        termFunc_r[i] <= 8'h00;
      end
    end else if (wrStrobe) begin
      case (paddr)
        `PMS_OFS_CTRL: runEn_r <= pwdata[`PMS_CTRL_RUN];
        `PMS_OFS_PRE_FREQ: preLoopFrequency_r <= pwdata[15:0];
        `PMS_OFS_PRE_EXIT: preLoopExitLevel_r <= pwdata[15:0];
        `PMS_OFS_PRE_DELAY: preLoopFailDelay_r <= pwdata[15:0];
        `PMS_OFS_SLEEP_DT: sleepDelayTime_r <= pwdata[15:0];
        `PMS_OFS_SLEEP_FREQ: sleepFrequency_r <= pwdata[15:0];
        `PMS_OFS_WAKE_LEVEL: wakeupLevel_r <= pwdata[15:0];
        `PMS_OFS_WAKE_MODE: wakeupModeSelect_r <= pwdata[1:0];
        `PMS_OFS_UNIT_SEL: displayUnitSelect_r <= pwdata[4:0];
        `PMS_OFS_UNIT_GAIN: displayUnitGain_r <= pwdata[15:0];
        `PMS_OFS_UNIT_SCALE: displayUnitScale_r <= pwdata[3:0];
        `PMS_OFS_ALT_PGAIN: alternateProportionalGain_r <= pwdata[15:0];
        `PMS_OFS_PRI_PGAIN: primaryProportionalGain_r <= pwdata[15:0];
        `PMS_OFS_PRI_ITERM: primaryIntegralTerm_r <= pwdata[15:0];
        `PMS_OFS_IRQ_MASK: irqMask_r <= pwdata[`PMS_IRQ_W-1:0];
        `PMS_OFS_TERM_LO: begin
          for (int i = 0; i < 4; i++) begin
            termFunc_r[i] <= pwdata[8*i +: 8];
          end
        end
        `PMS_OFS_TERM_HI: begin
          for (int i = 0; i < 3; i++) begin
            termFunc_r[i+4] <= pwdata[8*i +: 8];
          end
        end
        default: ;
      endcase
    end
  end

  // read mux and address decode
  always_comb begin
    readData = 32'h0;
    mapped = 1'b1;
    case (paddr)
      `PMS_OFS_CTRL: readData = {31'h0, runEn_r};
      `PMS_OFS_PRE_FREQ: readData = {16'h0, preLoopFrequency_r};
      `PMS_OFS_PRE_EXIT: readData = {16'h0, preLoopExitLevel_r};
      `PMS_OFS_PRE_DELAY: readData = {16'h0, preLoopFailDelay_r};
      `PMS_OFS_SLEEP_DT: readData = {16'h0, sleepDelayTime_r};
      `PMS_OFS_SLEEP_FREQ: readData = {16'h0, sleepFrequency_r};
      `PMS_OFS_WAKE_LEVEL: readData = {16'h0, wakeupLevel_r};
      `PMS_OFS_WAKE_MODE: readData = {30'h0, wakeupModeSelect_r};
      `PMS_OFS_UNIT_SEL: readData = {27'h0, displayUnitSelect_r};
      `PMS_OFS_UNIT_GAIN: readData = {16'h0, displayUnitGain_r};
      `PMS_OFS_UNIT_SCALE: readData = {28'h0, displayUnitScale_r};
      `PMS_OFS_ALT_PGAIN: readData = {16'h0, alternateProportionalGain_r};
      `PMS_OFS_PRI_PGAIN: readData = {16'h0, primaryProportionalGain_r};
      `PMS_OFS_PRI_ITERM: readData = {16'h0, primaryIntegralTerm_r};
      `PMS_OFS_TERM_LO: readData = {termFunc_r[3], termFunc_r[2], termFunc_r[1], termFunc_r[0]};
      `PMS_OFS_TERM_HI: readData = {8'h00, termFunc_r[6], termFunc_r[5], termFunc_r[4]};
      `PMS_OFS_STATUS: readData = {17'h0, termSync_r, gainSwitch, loopBypass, unitClass,
                                   3'(state_r)};
      `PMS_OFS_IRQ_STAT: readData = {28'h0, irqStat_r};
      `PMS_OFS_IRQ_MASK: readData = {28'h0, irqMask_r};
      `PMS_OFS_DISPLAY: readData = {16'h0, displayValue};
      default: mapped = 1'b0;
    endcase
  end

  // apb answer: one wait state, error on unmapped address
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= ~mapped;
      prdata <= pwrite ? 32'h0 : readData;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
  end

endmodule : pid_mode_sequencer

`default_nettype wire

/* rtl/pms_cfg.svh */
// register offsets, field positions, function and unit codes and timing counts of the sequencer
`ifndef PMS_CFG_SVH
`define PMS_CFG_SVH

// register byte offsets on the apb bus
`define PMS_OFS_CTRL 8'h00
`define PMS_OFS_PRE_FREQ 8'h04
`define PMS_OFS_PRE_EXIT 8'h08
`define PMS_OFS_PRE_DELAY 8'h0c
`define PMS_OFS_SLEEP_DT 8'h10
`define PMS_OFS_SLEEP_FREQ 8'h14
`define PMS_OFS_WAKE_LEVEL 8'h18
`define PMS_OFS_WAKE_MODE 8'h1c
`define PMS_OFS_UNIT_SEL 8'h20
`define PMS_OFS_UNIT_GAIN 8'h24
`define PMS_OFS_UNIT_SCALE 8'h28
`define PMS_OFS_ALT_PGAIN 8'h2c
`define PMS_OFS_PRI_PGAIN 8'h30
`define PMS_OFS_PRI_ITERM 8'h34
`define PMS_OFS_TERM_LO 8'h38
`define PMS_OFS_TERM_HI 8'h3c
`define PMS_OFS_STATUS 8'h40
`define PMS_OFS_IRQ_STAT 8'h44
`define PMS_OFS_IRQ_MASK 8'h48
`define PMS_OFS_DISPLAY 8'h4c

// control register fields
`define PMS_CTRL_RUN 0
`define PMS_CTRL_FAULT_CLR 1

// interrupt status fields
`define PMS_IRQ_PRE_FAIL 0
`define PMS_IRQ_SLEEP 1
`define PMS_IRQ_WAKE 2
`define PMS_IRQ_LOOP_START 3
`define PMS_IRQ_W 4

// terminal function codes
`define PMS_FUNC_LOOP_BYPASS 8'h17
`define PMS_FUNC_GAIN_SWITCH 8'h18
`define PMS_TERM_N 7

// display unit codes
`define PMS_UNIT_CELSIUS 5'h0b
`define PMS_UNIT_FAHRENHEIT 5'h0c
`define PMS_UNIT_CUSTOM_LO 5'h0d
`define PMS_UNIT_CUSTOM_HI 5'h10

// keypad code shown while sleeping, value arbitrary
`define PMS_SLEEP_DISPLAY_CODE 8'h5a

// wake-up modes
`define PMS_WAKE_BELOW 2'h0
`define PMS_WAKE_ABOVE 2'h1
`define PMS_WAKE_BEYOND 2'h2

// timer base: one millisecond tick
`define PMS_TICK_NS 1000000
`define PMS_CLK_NS 10
`define PMS_TICK_CYCLES (`PMS_TICK_NS / `PMS_CLK_NS)

`endif

/* rtl/pms_pkg.sv */
// types of the loop mode sequencer
package pms_pkg;
  typedef enum logic [2:0] {
    PMS_IDLE,
    PMS_PRE,
    PMS_LOOP,
    PMS_SLEEP,
    PMS_FAULT
  } pms_state_t;

  typedef enum logic [2:0] {
    PMS_CLS_PERCENT,
    PMS_CLS_PRESSURE,
    PMS_CLS_SPEED,
    PMS_CLS_ELECTRIC,
    PMS_CLS_CELSIUS,
    PMS_CLS_FAHRENHEIT,
    PMS_CLS_CUSTOM
  } pms_unit_class_t;
endpackage : pms_pkg

/* testbench/pms_properties.sv */
// port-level assertions of the loop mode sequencer
`include "pms_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module pms_properties #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] freqCmd,
  input wire logic outputEnable,
  input wire logic loopActive,
  input wire logic preLoopFault,
  input wire logic sleepWarning,
  input wire logic [7:0] keypadCode,
  input wire logic [2:0] unitClass
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  // setup cycle followed by first access cycle
  sequence setupAccess;
    psel && !penable ##1 psel && penable;
  endsequence
  // exactly one wait state before the answer
  sequence oneWait;
    !pready ##1 pready;
  endsequence

  // bus handshake timing
  a_apb_one_wait: assert property (setupAccess |-> oneWait)
    else $error("apb answer not after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr seen without pready");
  // sequencing and unit class outputs
  a_unit_class: assert property (unitClass <= 3'h6)
    else $error("unit class out of range");
  a_loop_output: assert property (loopActive |-> outputEnable && !sleepWarning)
    else $error("loop active without output");
  a_fault_blocks: assert property (preLoopFault |-> !outputEnable && freqCmd == 16'h0000)
    else $error("output not blocked in fault");
  a_fault_entry: assert property ($rose(preLoopFault) |-> $past(outputEnable) && !$past(loopActive))
    else $error("fault entered from outside pre-loop");
  a_fault_sticky: assert property (preLoopFault && !psel |=> preLoopFault)
    else $error("fault left without a clear write");
  a_sleep_entry: assert property ($rose(sleepWarning) |-> $past(loopActive))
    else $error("sleep entered from outside loop");
  a_sleep_blocks: assert property (sleepWarning |-> !outputEnable && freqCmd == 16'h0000)
    else $error("output running while asleep");
  a_sleep_code: assert property (sleepWarning |-> keypadCode == `PMS_SLEEP_DISPLAY_CODE)
    else $error("sleep code missing on keypad");
endmodule : pms_properties

bind pid_mode_sequencer pms_properties #(.TICK_CYCLES(TICK_CYCLES)) chk (
  .ref_clk, .srst, .psel, .penable, .pready, .pslverr, .freqCmd, .outputEnable,
  .loopActive, .preLoopFault, .sleepWarning, .keypadCode, .unitClass
);

`default_nettype wire

/* testbench/pms_drive_model.sv */
// power stage model: output frequency follows the command while enabled
`timescale 1ns/10ps
`default_nettype none

module pms_drive_model (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [15:0] freqCmd,
  input wire logic outputEnable,
  output logic [15:0] operatingFreq
);
  // one cycle of lag, zero when output is blocked
  always_ff @(posedge ref_clk) begin
    if (srst || !outputEnable) begin
      operatingFreq <= 16'h0000;
    end else begin
      operatingFreq <= freqCmd;
    end
  end
endmodule : pms_drive_model

`default_nettype wire

/* testbench/pid_mode_sequencer_tb.sv */
// self-checking bench of the loop mode sequencer
`include "pms_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module pid_mode_sequencer_tb;
  logic ref_clk, srst, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0] paddr, keypadCode;
  logic [31:0] pwdata, prdata, rdat;
  logic [6:0] termPins;
  logic [15:0] feedback, reference, operatingFreq, loopFreq, generalFreq, freqCmd;
  logic [15:0] activePGain, activeITerm, displayValue;
  logic outputEnable, loopActive, preLoopFault, sleepWarning, irq;
  logic [2:0] unitClass;
  logic [15:0] holdFb [3] = '{16'h0060, 16'h0040, 16'h00c0};
  logic [15:0] wakeFb [3] = '{16'h0040, 16'h0060, 16'h0080};
  int errorCnt, checkCount, cycles;

  pid_mode_sequencer #(.TICK_CYCLES(4)) uut (
    .ref_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .termPins, .feedback, .reference, .operatingFreq, .loopFreq,
    .generalFreq, .freqCmd, .outputEnable, .loopActive, .preLoopFault, .sleepWarning,
    .keypadCode, .activePGain, .activeITerm, .unitClass, .displayValue, .irq
  );
  pms_drive_model model (.ref_clk, .srst, .freqCmd, .outputEnable, .operatingFreq);

  // clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // hang guard
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errorCnt++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checkCount, errorCnt);
    if (errorCnt == 0 && checkCount > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      errorCnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // ends once pready is sampled high, else the hang guard ends it
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rdat);
  endtask : rd

  // main sequence
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    termPins = '0;
    feedback = 16'h0010;
    reference = 16'h0100;
    loopFreq = 16'h0200;
    generalFreq = 16'h0033;
    errorCnt = 0;
    checkCount = 0;
    cycles = 0;
    cyc(16);
    srst <= 1'b0;
    rd("unit gain", `PMS_OFS_UNIT_GAIN, 32'h1);
    rd("unmapped", 8'h50, 32'h0);
    chk("slverr", 32'h1, 32'(rerr));
    $display("test registers done");
    for (int u = 11; u <= 16; u++) begin
      wr(`PMS_OFS_UNIT_SEL, 32'(u));
      cyc(2);
      chk("unitClass", (u == 11) ? 4 : (u == 12) ? 5 : 6, 32'(unitClass));
    end
    wr(`PMS_OFS_UNIT_GAIN, 32'h3);
    wr(`PMS_OFS_UNIT_SCALE, 32'h1);
    cyc(2);
    chk("displayValue", 32'h18, 32'(displayValue));
    $display("test units done");
    wr(`PMS_OFS_ALT_PGAIN, 32'h77);
    wr(`PMS_OFS_PRI_PGAIN, 32'h11);
    wr(`PMS_OFS_PRI_ITERM, 32'h22);
    wr(`PMS_OFS_TERM_LO, 32'h1718);
    termPins <= 7'h01;
    cyc(5);
    chk("altGain", 32'h77, 32'(activePGain));
    chk("iTerm", 32'h22, 32'(activeITerm));
    termPins <= 7'h00;
    cyc(5);
    chk("priGain", 32'h11, 32'(activePGain));
    $display("test gain done");
    wr(`PMS_OFS_PRE_FREQ, 32'h100);
    wr(`PMS_OFS_PRE_EXIT, 32'h50);
    wr(`PMS_OFS_SLEEP_DT, 32'h4);
    wr(`PMS_OFS_SLEEP_FREQ, 32'h80);
    wr(`PMS_OFS_WAKE_LEVEL, 32'h50);
    wr(`PMS_OFS_CTRL, 32'h1);
    cyc(3);
    chk("preFreq", 32'h100, 32'(freqCmd));
    chk("preOut", 32'h1, 32'(outputEnable));
    chk("preLoop", 32'h0, 32'(loopActive));
    feedback <= 16'h0060;
    cyc(3);
    chk("loopOn", 32'h1, 32'(loopActive));
    chk("loopFreq", 32'h200, 32'(freqCmd));
    chk("irqMasked", 32'h0, 32'(irq));
    wr(`PMS_OFS_IRQ_MASK, 32'h8);
    cyc(2);
    chk("irqSet", 32'h1, 32'(irq));
    rd("irqStat", `PMS_OFS_IRQ_STAT, 32'h8);
    cyc(2);
    chk("irqClear", 32'h0, 32'(irq));
    $display("test pre-loop done");
    loopFreq <= 16'h0040;
    cyc(10);
    loopFreq <= 16'h0200;
    cyc(3);
    loopFreq <= 16'h0040;
    cyc(10);
    chk("noSleep", 32'h0, 32'(sleepWarning));
    for (int n = 0; n < 40 && sleepWarning !== 1'b1; n++) cyc(1);
    chk("sleep", 32'h1, 32'(sleepWarning));
    chk("keypad", 32'h5a, 32'(keypadCode));
    chk("sleepOut", 32'h0, 32'(outputEnable));
    for (int m = 0; m < 3; m++) begin
      feedback <= holdFb[m];
      wr(`PMS_OFS_WAKE_MODE, 32'(m));
      for (int n = 0; n < 40 && sleepWarning !== 1'b1; n++) cyc(1);
      cyc(5);
      chk("sleepHeld", 32'h1, 32'(sleepWarning));
      feedback <= wakeFb[m];
      cyc(3);
      chk("woken", 32'h0, 32'(sleepWarning));
    end
    $display("test sleep done");
    loopFreq <= 16'h0200;
    termPins <= 7'h02;
    cyc(5);
    chk("bypassLoop", 32'h0, 32'(loopActive));
    chk("bypassFreq", 32'h33, 32'(freqCmd));
    termPins <= 7'h00;
    cyc(5);
    chk("resumeLoop", 32'h1, 32'(loopActive));
    $display("test bypass done");
    wr(`PMS_OFS_CTRL, 32'h0);
    wr(`PMS_OFS_PRE_DELAY, 32'h2);
    feedback <= 16'h0010;
    wr(`PMS_OFS_CTRL, 32'h1);
    for (int n = 0; n < 40 && preLoopFault !== 1'b1; n++) cyc(1);
    chk("fault", 32'h1, 32'(preLoopFault));
    chk("faultOut", 32'h0, 32'(outputEnable));
    apb(1'b0, `PMS_OFS_IRQ_STAT, 32'h0);
    chk("failEvent", 32'h1, 32'(rdat[0]));
    wr(`PMS_OFS_CTRL, 32'h2);
    cyc(2);
    chk("faultClear", 32'h0, 32'(preLoopFault));
    rd("status", `PMS_OFS_STATUS, 32'h30);
    $display("test fault done");
    tally_and_finish();
  end
endmodule : pid_mode_sequencer_tb

`default_nettype wire
